/* core/ipm_irq_post_mask.sv */
// Interrupt post, mask and priority logic with an Avalon-MM register slave.
// Assumes event pulses and CPU signals come from logic on sys_clk.
//
// Summary of operation
// - Status read shows posted bit per source
// - Writing 0 clears posted when posting disabled
// - Writing 1 without posting enable changes nothing
// - Writing 1 with posting enable posts interrupt
// - Masked source still posts, never pending
// - Unmasked posted interrupt becomes pending
// - Each mask bit affects only its source
// - Mask bit 0 masks, 1 unmasks
// - First status register maps sources a
// - Second status register maps sources b
// - Third status register maps sources c
// - Posting enable lives in bit 7
// - Third mask register mirrors third status
// - Third mask bit 6 is plain storage
// - Second mask register mirrors second status
// - Posted stays until taken or cleared
// - Priority encoder picks highest, gated by enable
// - Lower vector number wins, vector is 4x
`timescale 1ns/10ps
`include "ipm_defines.svh"

module ipm_irq_post_mask
    import ipm_pkg::*;
#(
    parameter int SOURCES = 24
)
(
    input  wire logic        sys_clk,
    input  wire logic        rst_b,
    input  wire logic [7:0]  avs_address,
    input  wire logic        avs_read,
    input  wire logic        avs_write,
    input  wire logic [31:0] avs_writedata,
    input  wire logic [3:0]  avs_byteenable,
    output logic      [31:0] avs_readdata,
    output logic             avs_waitrequest,
    input  wire ipm_events_s events,
    input  wire logic        global_irq_enable,
    input  wire logic        irq_take,
    output ipm_irq_s         irq_out
);

    localparam logic [5*SOURCES-1:0] PRIO = `IPM_PRIO_TABLE;

    logic [SOURCES-1:0] posted_reg;
    logic [SOURCES-1:0] posted_next;
    logic [7:0]         enable_a_reg;
    logic [7:0]         enable_b_reg;
    logic [7:0]         enable_c_reg;
    logic               sw_post_reg;
    logic               waitrequest_reg;
    logic [31:0]        readdata_reg;
    logic [31:0]        readdata_next;
    ipm_irq_s           irq_reg;
    ipm_irq_s           irq_next;

    logic               wr_go;
    logic               lane0;
    logic [7:0]         wdata;
    logic [SOURCES-1:0] mask_all;
    logic [SOURCES-1:0] pending;
    logic [SOURCES-1:0] valid_bits;
    logic [SOURCES-1:0] event_flat;
    logic [2:0]         wr_group;
    logic               wr_byte;
    logic               hit_post_a;
    logic               hit_post_b;
    logic               hit_post_c;
    logic               hit_sw_post;
    logic               hit_enable_a;
    logic               hit_enable_b;
    logic               hit_enable_c;

    // A write lands only at the edge where waitrequest is seen low
    assign wr_go = avs_write && !waitrequest_reg;
    assign lane0 = avs_byteenable[0];
    assign wdata = avs_writedata[7:0];
    assign event_flat = events;
    assign valid_bits = {`IPM_POST_C_BITS, 8'hff, 8'hff};

    // Index decode, shared by every write path so all registers agree
    assign wr_byte      = wr_go && lane0;
    assign hit_post_a   = (avs_address == `IPM_IDX_POST_A);
    assign hit_post_b   = (avs_address == `IPM_IDX_POST_B);
    assign hit_post_c   = (avs_address == `IPM_IDX_POST_C);
    assign hit_sw_post  = (avs_address == `IPM_IDX_SW_POST);
    assign hit_enable_a = (avs_address == `IPM_IDX_ENABLE_A);
    assign hit_enable_b = (avs_address == `IPM_IDX_ENABLE_B);
    assign hit_enable_c = (avs_address == `IPM_IDX_ENABLE_C);

    always_comb
    begin
        wr_group = 3'h0;
        if (wr_byte)
        begin
            wr_group[0] = hit_post_a;
            wr_group[1] = hit_post_b;
            wr_group[2] = hit_post_c;
        end
    end

    // Bus answer: one wait cycle, then waitrequest low for one cycle
    always_ff @(posedge sys_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            waitrequest_reg <= 1'b1;
        end
        else if ((avs_read || avs_write) && waitrequest_reg)
        begin
            waitrequest_reg <= 1'b0;
        end
        else
        begin
            waitrequest_reg <= 1'b1;
        end
    end

    // Read mux; unmapped indexes read zero, reserved bits read zero
    always_comb
    begin
        readdata_next = 32'h0000_0000;
        unique case (avs_address)
            `IPM_IDX_POST_A:   readdata_next[7:0] = posted_reg[7:0];
            `IPM_IDX_POST_B:   readdata_next[7:0] = posted_reg[15:8];
            `IPM_IDX_POST_C:   readdata_next[7:0] = posted_reg[23:16];
            `IPM_IDX_SW_POST:  readdata_next[`IPM_SW_POST_POS] = sw_post_reg;
            `IPM_IDX_ENABLE_C: readdata_next[7:0] = enable_c_reg;
            `IPM_IDX_ENABLE_A: readdata_next[7:0] = enable_a_reg;
            `IPM_IDX_ENABLE_B: readdata_next[7:0] = enable_b_reg;
            default:           readdata_next = 32'h0000_0000;
        endcase
    end

    always_ff @(posedge sys_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            readdata_reg <= 32'h0000_0000;
        end
        else if (avs_read && waitrequest_reg)
        begin
            readdata_reg <= readdata_next;
        end
    end

    // Mask registers, each register in its own process
    always_ff @(posedge sys_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            enable_a_reg <= `IPM_REG_RESET;
        end
        else if (wr_byte && hit_enable_a)
        begin
            enable_a_reg <= wdata;
        end
    end

    always_ff @(posedge sys_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            enable_b_reg <= `IPM_REG_RESET;
        end
        else if (wr_byte && hit_enable_b)
        begin
            enable_b_reg <= wdata;
        end
    end

    // Bit 7 is not stored so it always reads back zero
    always_ff @(posedge sys_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            enable_c_reg <= `IPM_REG_RESET;
        end
        else if (wr_byte && hit_enable_c)
        begin
            enable_c_reg <= wdata & `IPM_ENABLE_C_BITS;
        end
    end

    // Software posting enable, the only stored bit of its register
    always_ff @(posedge sys_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            sw_post_reg <= 1'b0;
        end
        else if (wr_byte && hit_sw_post)
        begin
            sw_post_reg <= wdata[`IPM_SW_POST_POS];
        end
    end

    // Per-source posting flop
    genvar gi;
    generate
        for (gi = 0; gi < SOURCES; gi++)
        begin : g_post
            logic wr_here;
            logic set_bit;
            logic clr_bit;

            assign wr_here = wr_group[gi / 8];
            // Posting by software acts as a hardware event would
            assign set_bit = event_flat[gi]
                           || (wr_here && sw_post_reg && wdata[gi % 8]);
            // Zero clears only while posting is disabled; a written one never clears
            assign clr_bit = (wr_here && !sw_post_reg && !wdata[gi % 8])
                           || (irq_take && irq_reg.request
                               && (irq_reg.source == 5'(gi)));

            always_comb
            begin
                if (!valid_bits[gi])
                begin
                    posted_next[gi] = 1'b0;
                end
                else if (set_bit)
                begin
                    posted_next[gi] = 1'b1;
                end
                else if (clr_bit)
                begin
                    posted_next[gi] = 1'b0;
                end
                else
                begin
                    posted_next[gi] = posted_reg[gi];
                end
            end

            always_ff @(posedge sys_clk or negedge rst_b)
            begin
                if (!rst_b)
                begin
                    posted_reg[gi] <= 1'b0;
                end
                else
                begin
                    posted_reg[gi] <= posted_next[gi];
                end
            end
        end
    endgenerate

    // Masking never touches the posted state, only what reaches the encoder
    assign mask_all = {enable_c_reg, enable_b_reg, enable_a_reg};
    assign pending  = posted_reg & mask_all & valid_bits;

    // Lowest priority number among pending sources wins
    always_comb
    begin
        logic [4:0] best_prio;
        logic [4:0] best_src;
        logic       found;
        best_prio = `IPM_PRIO_NONE;
        best_src  = 5'h00;
        found     = 1'b0;
        for (int i = 0; i < SOURCES; i++)
        begin
            if (pending[i] && (PRIO[i*5 +: 5] < best_prio))
            begin
                best_prio = PRIO[i*5 +: 5];
                best_src  = 5'(i);
                found     = 1'b1;
            end
        end
        irq_next.request = found && global_irq_enable;
        irq_next.source  = best_src;
        // Vector reads zero when nothing is pending, never the idle marker
        if (found)
        begin
            irq_next.vector = {1'b0, best_prio, 2'b00};
        end
        else
        begin
            irq_next.vector = 8'h00;
        end
    end

    // Registered so the outputs stay glitch free; costs one cycle of latency
    always_ff @(posedge sys_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            irq_reg <= '0;
        end
        else
        begin
            irq_reg <= irq_next;
        end
    end

    assign avs_waitrequest = waitrequest_reg;
    assign avs_readdata    = readdata_reg;
    assign irq_out         = irq_reg;

endmodule : ipm_irq_post_mask

/* core/ipm_defines.svh */
// Constants for the interrupt post and mask register block.
// Assumes inclusion by bare name from the block module.
`ifndef IPM_DEFINES_SVH
`define IPM_DEFINES_SVH

// Register indexes; the byte address on the bus is four times the index
`define IPM_IDX_POST_A      8'hda
`define IPM_IDX_POST_B      8'hdb
`define IPM_IDX_POST_C      8'hdc
`define IPM_IDX_SW_POST     8'hde
`define IPM_IDX_ENABLE_C    8'hdf
`define IPM_IDX_ENABLE_A    8'he0
`define IPM_IDX_ENABLE_B    8'he1

// Field positions and implemented-bit masks
`define IPM_SW_POST_BIT     3
`define IPM_SW_POST_POS     7
`define IPM_POST_C_BITS     8'h3f
`define IPM_ENABLE_C_BITS   8'h7f
`define IPM_SW_POST_BITS    8'h80
`define IPM_REG_RESET       8'h00

// Priority of each source, flat index group*8+bit, bit 0 of group a lowest
`define IPM_PRIO_TABLE {5'h00, 5'h00, 5'h15, 5'h14, 5'h13, 5'h12, 5'h11, 5'h10, \
                        5'h0f, 5'h0e, 5'h0d, 5'h0c, 5'h0b, 5'h0a, 5'h09, 5'h08, \
                        5'h06, 5'h19, 5'h07, 5'h05, 5'h04, 5'h03, 5'h02, 5'h01}
`define IPM_PRIO_NONE       5'h1f
`define IPM_VEC_SHIFT       2

`endif

/* core/ipm_pkg.sv */
// Types for the interrupt post and mask register block.
// Assumes the defines header sits beside it.
package ipm_pkg;

    typedef logic [7:0] ipm_byte_t;

    // Hardware event pulses, one per source, grouped as the status registers
    typedef struct packed {
        ipm_byte_t group_c;
        ipm_byte_t group_b;
        ipm_byte_t group_a;
    } ipm_events_s;

    // Request presented to the CPU core
    typedef struct packed {
        logic       request;
        logic [4:0] source;
        ipm_byte_t  vector;
    } ipm_irq_s;

endpackage : ipm_pkg

/* tb/ipm_cpu_model.sv */
// CPU side partner: takes a presented interrupt after a chosen wait.
// Assumes irq_out and irq_take share sys_clk with the block.
`timescale 1ns/10ps
module ipm_cpu_model
    import ipm_pkg::*;
(
    input  wire logic       sys_clk,
    input  wire logic       rst_b,
    input  wire ipm_irq_s   irq_out,
    input  wire logic       take_on,
    input  wire logic [3:0] delay,
    output logic            irq_take
);
    logic [3:0] wait_cnt;
    // Delay of 1 or more keeps a stale request after a take from being taken twice
    always_ff @(posedge sys_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            wait_cnt <= 4'h0;
            irq_take <= 1'b0;
        end
        else
        begin
            wait_cnt <= (!irq_out.request || irq_take) ? 4'h0 : wait_cnt + 4'h1;
            irq_take <= take_on && irq_out.request && !irq_take && wait_cnt == delay;
        end
    end
endmodule : ipm_cpu_model

/* tb/ipm_irq_post_mask_sva.sv */
// Checker for the post and mask block.
// Assumes it is bound to the block top and sees its ports only.
`timescale 1ns/10ps
module ipm_post_mask_chk
    import ipm_pkg::*;
(
    input wire logic        sys_clk,
    input wire logic        rst_b,
    input wire logic [7:0]  avs_address,
    input wire logic        avs_read,
    input wire logic        avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0]  avs_byteenable,
    input wire logic [31:0] avs_readdata,
    input wire logic        avs_waitrequest,
    input wire ipm_events_s events,
    input wire logic        global_irq_enable,
    input wire logic        irq_take,
    input wire ipm_irq_s    irq_out
);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!rst_b);
    logic rd_ok;
    assign rd_ok = avs_read && !avs_waitrequest;
    chk_wait_one: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
        else $error("bus answer late");
    chk_wait_back: assert property (!avs_waitrequest |=> avs_waitrequest)
        else $error("answer held too long");
    chk_rsvd_c: assert property (rd_ok && avs_address == 8'hdc |-> avs_readdata[7:6] == 2'b00)
        else $error("reserved status bits set");
    chk_rsvd_sw: assert property (rd_ok && avs_address == 8'hde |-> avs_readdata[6:0] == 7'h00)
        else $error("reserved control bits set");
    chk_rsvd_en: assert property (rd_ok && avs_address == 8'hdf |-> !avs_readdata[7])
        else $error("reserved enable bit set");
    chk_unmapped_zero: assert property (rd_ok && (avs_address == 8'hdd || avs_address < 8'hda
        || avs_address > 8'he1) |-> avs_readdata == 32'h0)
        else $error("unmapped read not zero");
    chk_gie_gate: assert property (!global_irq_enable |=> !irq_out.request)
        else $error("request without global enable");
    chk_vec_first: assert property (irq_out.request && irq_out.source == 5'h00 |-> irq_out.vector == 8'h04)
        else $error("wrong vector for first source");
    chk_take_clears: assert property (irq_take && irq_out.request && events == 24'h0 && !avs_write
        |=> ##1 (!irq_out.request || irq_out.source != $past(irq_out.source, 2)))
        else $error("taken interrupt still presented");
endmodule : ipm_post_mask_chk
bind ipm_irq_post_mask ipm_post_mask_chk i_chk (.sys_clk, .rst_b, .avs_address, .avs_read, .avs_write,
    .avs_writedata, .avs_byteenable, .avs_readdata, .avs_waitrequest, .events, .global_irq_enable,
    .irq_take, .irq_out);

/* tb/test_ipm_irq_post_mask.sv */
// Testbench for the post and mask block with the CPU partner model.
// Assumes package, design, model and checker are compiled first.
`timescale 1ns/10ps
module test_ipm_irq_post_mask import ipm_pkg::*;;
    logic        sys_clk, rst_b, avs_read, avs_write, avs_waitrequest, global_irq_enable, take_on, irq_take;
    logic [7:0]  avs_address, rd;
    logic [31:0] avs_writedata, avs_readdata;
    logic [3:0]  delay;
    ipm_events_s events;
    ipm_irq_s    irq_out;
    int          fail_count, check_count;
    ipm_irq_post_mask i_dut (.sys_clk(sys_clk), .rst_b(rst_b), .avs_address(avs_address), .avs_read(avs_read),
        .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(4'h1), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest), .events(events), .global_irq_enable(global_irq_enable),
        .irq_take(irq_take), .irq_out(irq_out));
    ipm_cpu_model i_cpu (.sys_clk(sys_clk), .rst_b(rst_b), .irq_out(irq_out), .take_on(take_on),
        .delay(delay), .irq_take(irq_take));
    initial
    begin
        sys_clk = 1'b0;
        forever #5 sys_clk = ~sys_clk;
    end
    task chk(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp)
            begin
            fail_count++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
            end
    endtask : chk
    // Holds the request until waitrequest is seen low, then releases a cycle apart
    task bus(input logic wr, input logic [7:0] a, input logic [7:0] d);
        int n;
        avs_address <= a;
        avs_write <= wr;
        avs_read <= !wr;
        avs_writedata <= {24'h0, d};
        n = 0;
        do
            begin
            @(negedge sys_clk);
            n++;
            end
        while (avs_waitrequest !== 1'b0 && n < 50);
        if (n >= 50) fail_count++;
        rd = avs_readdata[7:0];
        @(posedge sys_clk);
        avs_read <= 1'b0;
        avs_write <= 1'b0;
        @(posedge sys_clk);
    endtask : bus
    task rchk(input logic [7:0] a, input logic [7:0] exp);
        bus(1'b0, a, 8'h00);
        chk({24'h0, rd}, {24'h0, exp});
    endtask : rchk
    task pulse(input logic [23:0] v);
        events <= ipm_events_s'(v);
        @(posedge sys_clk);
        events <= 24'h0;
        repeat (3) @(posedge sys_clk);
    endtask : pulse
    task take_vec(input logic [7:0] exp);
        int n;
        n = 0;
        do
            begin
            @(negedge sys_clk);
            n++;
            end
        while (irq_take !== 1'b1 && n < 40);
        if (n >= 40) fail_count++;
        chk({24'h0, irq_out.vector}, {24'h0, exp});
        @(posedge sys_clk);
    endtask : take_vec
    task t_reset;
        for (int i = 8'hda; i <= 8'he1; i++) rchk(8'(i), 8'h00);
    endtask : t_reset
    task t_clear;
        pulse(24'h000008);
        rchk(8'hda, 8'h08);
        bus(1'b1, 8'hda, 8'hff);
        rchk(8'hda, 8'h08);
        bus(1'b1, 8'hda, 8'hf7);
        rchk(8'hda, 8'h00);
    endtask : t_clear
    task t_swpost;
        bus(1'b1, 8'hde, 8'hff);
        rchk(8'hde, 8'h80);
        bus(1'b1, 8'hdc, 8'hff);
        rchk(8'hdc, 8'h3f);
        bus(1'b1, 8'hdb, 8'ha5);
        bus(1'b1, 8'hdb, 8'h00);
        rchk(8'hdb, 8'ha5);
        bus(1'b1, 8'hde, 8'h00);
        bus(1'b1, 8'hdb, 8'h00);
        bus(1'b1, 8'hdc, 8'h00);
        bus(1'b1, 8'hdf, 8'hff);
        rchk(8'hdf, 8'h7f);
        bus(1'b1, 8'hdf, 8'h00);
    endtask : t_swpost
    task t_mask;
        bus(1'b1, 8'he1, 8'h01);
        pulse(24'h000300);
        chk(irq_out.request, 1'b0);
        global_irq_enable <= 1'b1;
        repeat (3) @(posedge sys_clk);
        chk({irq_out.request, irq_out.source, irq_out.vector}, {1'b1, 5'h08, 8'h20});
        rchk(8'hdb, 8'h03);
        take_on <= 1'b1;
        take_vec(8'h20);
        repeat (4) @(posedge sys_clk);
        rchk(8'hdb, 8'h02);
        chk(irq_out.request, 1'b0);
        bus(1'b1, 8'hdb, 8'h00);
    endtask : t_mask
    task t_prio;
        delay <= 4'h6;
        bus(1'b1, 8'he0, 8'hff);
        pulse(24'h000041);
        take_vec(8'h04);
        take_vec(8'h64);
        repeat (4) @(posedge sys_clk);
        rchk(8'hda, 8'h00);
    endtask : t_prio
    task tally_and_finish;
        $display("Checks %0d, errors %0d", check_count, fail_count);
        if (fail_count == 0 && check_count > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask : tally_and_finish
    initial
    begin
        #50000;
        fail_count++;
        tally_and_finish();
    end
    initial
    begin
        {rst_b, avs_read, avs_write, global_irq_enable, take_on} = 5'h00;
        {avs_address, avs_writedata, events, delay} = {8'h00, 32'h0, 24'h0, 4'h2};
        {fail_count, check_count} = {32'h0, 32'h0};
        repeat (4) @(posedge sys_clk);
        rst_b <= 1'b1;
        @(posedge sys_clk);
        t_reset();
        t_clear();
        t_swpost();
        t_mask();
        t_prio();
        tally_and_finish();
    end
endmodule : test_ipm_irq_post_mask
